//--- core/scrd_top.sv
// scaler card host register interface and counter control
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RQ1: host reaches card only through port accesses at switch base, default 330h.
// RQ2: 16-bit control word at offset 0, writable and readable.
// RQ3: bit 0 arms card; bit 1 drives armed state onto shared run line.
// RQ4: bit 2 set: counters advance only while run line is true.
// RQ5: bit 3 set: release run line once a terminal count is reached.
// RQ6: bit 4 picks gate active level: 0 low, 1 high.
// RQ7: bit 5 enables common gate; cleared gate has no effect.
// RQ8: bit 8 loads start values by software; bit 7 enables external load.
// RQ9: bit 9 snapshots all counters at once into capture registers.
// RQ10: bits 10 and 11 enable terminal mode for scalers 0 and 1.
// RQ11: bit 13 makes scaler 0 count a 10 ns internal time base.
// RQ12: bit 14 clear halts while line false; set stops on falling edge.
// RQ13: 8-bit channel-select register at offset 1, writable and readable.
// RQ14: low four channel-select bits pick scaler shown at capture readout.
// RQ15: upper four bits pick carry source: 0 carry, 1..15 bits 30..16.
// RQ16: read-only status at offset 3: reached, run, gate, load, version.
// RQ17: scaler 0 in terminal mode starts at preset, stops at FFFFFFFh.
// RQ18: scaler 1 behaves likewise with its own preset.
// RQ19: start values split into 16-bit halves at offsets 2,4 and 6,8.
// RQ20: selected snapshot low and high halves read at offsets 10 and 12.
// RQ21: bit 12 clears reached flag; bit 15 resets system; bit 6 written 1.
module scrd_top
    import scrd_pkg::*;
#(
    parameter logic [15:0] BASE_ADDR = BASE_DEFAULT,
    parameter logic        VERSION   = 1'b0
) (
    // clock and reset
    input  wire logic            CLK_SYS_IN,
    input  wire logic            ARST_N_IN,
    // host port access
    input  wire logic [15:0]     PORT_ADDR_IN,
    input  wire logic            PORT_RD_IN,
    input  wire logic            PORT_WR_IN,
    input  wire logic [15:0]     PORT_WDATA_IN,
    output logic      [15:0]     PORT_RDATA_OUT,
    // field inputs
    input  wire logic [NCH-1:0]  COUNT_IN,
    input  wire logic            WINDOW_IN,
    input  wire logic            LOAD_IN,
    // shared run line, open drain
    input  wire logic            RUN_LINE_IN,
    output logic                 RUN_LINE_OUT,
    output logic                 RUN_LINE_OE_OUT,
    // carry and status
    output logic                 CARRY_PULSE_OUTPUT_OUT,
    output logic                 TERMINAL_FLAG_OUT
);

    scrd_state_s st_reg, st_next;
    // two-flop synchronisers for pins, stage 1 is read only by stage 2
    logic [NCH+2:0] sync1_reg, sync2_reg, prev_reg;
    logic [NCH-1:0] cnt_s, cnt_rise;
    logic           win_s, load_s, run_s, load_rise;

    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg  <= '0;
        end else begin
            sync1_reg <= {RUN_LINE_IN, LOAD_IN, WINDOW_IN, COUNT_IN};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign cnt_s     = sync2_reg[NCH-1:0];
    assign win_s     = sync2_reg[NCH];
    assign load_s    = sync2_reg[NCH+1];
    assign run_s     = sync2_reg[NCH+2];
    assign cnt_rise  = cnt_s & ~prev_reg[NCH-1:0];
    assign load_rise = load_s & ~prev_reg[NCH+1];

    scrd_bus_s bus;
    logic      hit;
    assign hit = (PORT_ADDR_IN >= BASE_ADDR)
              && ((PORT_ADDR_IN - BASE_ADDR) < 16'h0010); // see RQ1
    assign bus.rd    = PORT_RD_IN && hit;
    assign bus.wr    = PORT_WR_IN && hit;
    assign bus.addr  = PORT_ADDR_IN[3:0] - BASE_ADDR[3:0];
    assign bus.wdata = PORT_WDATA_IN;

    logic [15:0] ctl;
    logic        armed, gate_ok, run_ok, do_load, term_hit;
    logic [1:0]  reached;
    logic [31:0] sel_snap;
    logic [4:0]  tap;

    assign ctl      = st_reg.control;
    assign armed    = ctl[BIT_ARM]; // see RQ3
    // gate level compared against chosen polarity
    assign gate_ok  = !ctl[BIT_WIN_EN]
                   || (win_s == ctl[BIT_WIN_POL]); // see RQ6 see RQ7
    assign run_ok   = !ctl[BIT_RUN_WATCH]
                   || (run_s && !st_reg.finished); // see RQ4 see RQ12
    assign do_load  = (bus.wr && bus.addr == OFF_CONTROL
                       && bus.wdata[BIT_SW_LOAD])
                   || (ctl[BIT_EXT_XFER_EN] && load_rise); // see RQ8
    assign sel_snap = st_reg.snap[st_reg.chsel[3:0]]; // see RQ14
    assign tap      = 5'd31 - {1'b0, st_reg.chsel[7:4]};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_term
            // terminal mode halts the channel at the terminal count
            assign reached[g] = ctl[BIT_TERM_CH0 + g]
                && st_reg.count[g] == TERMINAL_COUNT; // see RQ17 see RQ18
        end
    endgenerate
    assign term_hit = |reached;

    always_comb begin
        st_next = st_reg;
        st_next.run_q = run_s;
        // host register writes
        if (bus.wr) begin
            unique case (bus.addr)
                OFF_CONTROL: begin
                    st_next.control = bus.wdata; // see RQ2
                    // command bits act once and do not stay set
                    st_next.control[BIT_SW_LOAD]   = 1'b0;
                    st_next.control[BIT_SNAPSHOT]  = 1'b0;
                    st_next.control[BIT_TERM_CLR]  = 1'b0;
                    st_next.control[BIT_SYS_RESET] = 1'b0;
                end
                OFF_CHSEL:     st_next.chsel = bus.wdata[7:0]; // see RQ13
                OFF_START_LO0: st_next.start_val[0][15:0]  = bus.wdata;
                OFF_START_HI0: st_next.start_val[0][31:16] = bus.wdata;
                OFF_START_LO1: st_next.start_val[1][15:0]  = bus.wdata;
                OFF_START_HI1: st_next.start_val[1][31:16] = bus.wdata;
                default: ; // see RQ19
            endcase
        end
        // counting
        for (int i = 0; i < NCH; i++) begin
            if (armed && gate_ok && run_ok && !(i < 2 && reached[i[0]])) begin
                if (i == 0 && ctl[BIT_TIMER]) begin
                    st_next.count[i] = st_reg.count[i]
                                     + 32'(TIMER_STEP); // see RQ11
                end else if (cnt_rise[i]) begin
                    st_next.count[i] = st_reg.count[i] + 32'h0000_0001;
                end
            end
        end
        // falling run edge finishes counting in stop mode
        if (ctl[BIT_STOP_FALL] && st_reg.run_q && !run_s) begin
            st_next.finished = 1'b1; // see RQ12
        end
        if (do_load) begin
            st_next.count[0] = st_reg.start_val[0];
            st_next.count[1] = st_reg.start_val[1];
            for (int i = 2; i < NCH; i++) st_next.count[i] = '0;
            st_next.finished = 1'b0;
        end
        if (bus.wr && bus.addr == OFF_CONTROL && bus.wdata[BIT_SNAPSHOT]) begin
            st_next.snap = st_reg.count; // see RQ9
        end
        // a new terminal event wins over a clear in the same cycle
        if (bus.wr && bus.addr == OFF_CONTROL && bus.wdata[BIT_TERM_CLR]) begin
            st_next.term_flag = 1'b0; // see RQ21
        end
        if (term_hit) st_next.term_flag = 1'b1; // see RQ10
        // carry: overflow or selected data bit
        if (st_reg.chsel[7:4] == 4'h0) begin
            st_next.carry = st_reg.count[0] == 32'hFFFF_FFFF; // see RQ15
        end else begin
            st_next.carry = st_reg.count[0][tap];
        end
        // read data, from a register, back to zero in each cycle without a read
        st_next.rdata = 16'h0000;
        if (bus.rd) begin
            unique case (bus.addr)
                OFF_CONTROL:   st_next.rdata = ctl;
                OFF_CHSEL:     st_next.rdata = {8'h00, st_reg.chsel};
                OFF_START_LO0: st_next.rdata = st_reg.start_val[0][15:0];
                OFF_STATUS:    st_next.rdata = {11'h000, VERSION, load_s,
                                   win_s, run_s, st_reg.term_flag}; // see RQ16
                OFF_START_HI0: st_next.rdata = st_reg.start_val[0][31:16];
                OFF_START_LO1: st_next.rdata = st_reg.start_val[1][15:0];
                OFF_START_HI1: st_next.rdata = st_reg.start_val[1][31:16];
                OFF_SNAP_LO:   st_next.rdata = sel_snap[15:0]; // see RQ20
                OFF_SNAP_HI:   st_next.rdata = sel_snap[31:16];
                default:       st_next.rdata = 16'h0000;
            endcase
        end
        // software system reset returns everything except the pin synchronisers and edge stage to reset state
        if (bus.wr && bus.addr == OFF_CONTROL && bus.wdata[BIT_SYS_RESET]) begin
            st_next         = '0;
            st_next.control = CONTROL_RESET; // see RQ21
            st_next.chsel   = CHSEL_RESET;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            st_reg         <= '0;
            st_reg.control <= CONTROL_RESET;
            st_reg.chsel   <= CHSEL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign PORT_RDATA_OUT = st_reg.rdata;
    // line is pulled low (not ready) unless armed, driving allowed and not dropped by bit 3 on terminal flag
    assign RUN_LINE_OUT    = 1'b0;
    assign RUN_LINE_OE_OUT = !(ctl[BIT_RUN_DRIVE] && armed
                          && !(ctl[BIT_RUN_DROP] && st_reg.term_flag));
    // see RQ3 see RQ5
    assign CARRY_PULSE_OUTPUT_OUT = !st_reg.carry;
    assign TERMINAL_FLAG_OUT      = st_reg.term_flag;

endmodule // scrd_top

`default_nettype wire

//--- shared/scrd_pkg.sv
// package: register map, control fields and state for the scaler card block
package scrd_pkg;
    localparam logic [15:0] BASE_DEFAULT     = 16'h0330;
    localparam logic [3:0]  OFF_CONTROL      = 4'h0;
    localparam logic [3:0]  OFF_CHSEL        = 4'h1;
    localparam logic [3:0]  OFF_START_LO0    = 4'h2;
    localparam logic [3:0]  OFF_STATUS       = 4'h3;
    localparam logic [3:0]  OFF_START_HI0    = 4'h4;
    localparam logic [3:0]  OFF_START_LO1    = 4'h6;
    localparam logic [3:0]  OFF_START_HI1    = 4'h8;
    localparam logic [3:0]  OFF_SNAP_LO      = 4'ha;
    localparam logic [3:0]  OFF_SNAP_HI      = 4'hc;
    localparam int BIT_ARM          = 0;
    localparam int BIT_RUN_DRIVE    = 1;
    localparam int BIT_RUN_WATCH    = 2;
    localparam int BIT_RUN_DROP     = 3;
    localparam int BIT_WIN_POL      = 4;
    localparam int BIT_WIN_EN       = 5;
    localparam int BIT_MUST_ONE     = 6;
    localparam int BIT_EXT_XFER_EN  = 7;
    localparam int BIT_SW_LOAD      = 8;
    localparam int BIT_SNAPSHOT     = 9;
    localparam int BIT_TERM_CH0     = 10;
    localparam int BIT_TERM_CH1     = 11;
    localparam int BIT_TERM_CLR     = 12;
    localparam int BIT_TIMER        = 13;
    localparam int BIT_STOP_FALL    = 14;
    localparam int BIT_SYS_RESET    = 15;
    localparam logic [15:0] CONTROL_RESET  = 16'h0040;
    localparam logic [7:0]  CHSEL_RESET    = 8'h00;
    localparam logic [31:0] TERMINAL_COUNT = 32'h0FFF_FFFF;
    localparam int TIMEBASE_NS  = 10;
    localparam int CLK_PERIOD_NS = 100;
    // ticks of the 10 ns time base per system clock, at least one
    localparam int TIMER_STEP =
        (CLK_PERIOD_NS / TIMEBASE_NS) < 1 ? 1 : CLK_PERIOD_NS / TIMEBASE_NS;
    localparam int NCH = 12;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } scrd_bus_s;

    typedef struct packed {
        logic [15:0]          control;
        logic [7:0]           chsel;
        logic [1:0][31:0]     start_val;
        logic [NCH-1:0][31:0] count;
        logic [NCH-1:0][31:0] snap;
        logic                 term_flag;
        logic                 finished;
        logic                 run_q;
        logic [15:0]          rdata;
        logic                 carry;
    } scrd_state_s;
endpackage : scrd_pkg

//--- tb/scrd_top_checker.sv
// checker: port-level assertions for the scaler card registers
`timescale 1ns/1ps
`default_nettype none
module scrd_chk
    import scrd_pkg::*;
#(
    parameter logic [15:0] BASE_ADDR = BASE_DEFAULT
) (
    input  wire logic        CLK_SYS_IN,
    input  wire logic        ARST_N_IN,
    input  wire logic [15:0] PORT_ADDR_IN,
    input  wire logic        PORT_RD_IN,
    input  wire logic        PORT_WR_IN,
    input  wire logic [15:0] PORT_WDATA_IN,
    input  wire logic [15:0] PORT_RDATA_OUT,
    input  wire logic        RUN_LINE_OE_OUT,
    input  wire logic        TERMINAL_FLAG_OUT
);
    logic [15:0]      off;
    logic [15:0]      exp;
    logic             hole;
    logic [15:0]      ctl_reg;
    logic [7:0]       sel_reg;
    logic [3:0][15:0] sv_reg;
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!ARST_N_IN);
    assign off = PORT_ADDR_IN - BASE_ADDR;
    // shadow of the writable registers; command bits never read back
    always_comb begin
        hole = 1'b0;
        exp  = 16'h0000;
        case (off)
            16'h0000: exp = ctl_reg;
            16'h0001: exp = {8'h00, sel_reg};
            16'h0002, 16'h0004, 16'h0006, 16'h0008: exp = sv_reg[2'(off[3:1] - 3'd1)];
            16'h0003, 16'h000a, 16'h000c: hole = 1'b0;
            default: hole = 1'b1;
        endcase
    end
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            ctl_reg <= CONTROL_RESET;
            sel_reg <= CHSEL_RESET;
            sv_reg  <= '0;
        end else if (PORT_WR_IN && off == 16'h0000) begin
            ctl_reg <= PORT_WDATA_IN & 16'h6cff;
        end else if (PORT_WR_IN && off == 16'h0001) begin
            sel_reg <= PORT_WDATA_IN[7:0];
        end else if (PORT_WR_IN && off inside {16'h2, 16'h4, 16'h6, 16'h8}) begin
            sv_reg[2'(off[3:1] - 3'd1)] <= PORT_WDATA_IN;
        end
    end
    property p_rd_idle;
        !PORT_RD_IN |=> PORT_RDATA_OUT == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    property p_ctl_rb;
        PORT_RD_IN && off == 16'h0000 |=> PORT_RDATA_OUT == $past(exp);
    endproperty
    a_ctl_rb: assert property (p_ctl_rb)
        else $error("control readback wrong");
    property p_sel_rb;
        PORT_RD_IN && off == 16'h0001 |=> PORT_RDATA_OUT == $past(exp);
    endproperty
    a_sel_rb: assert property (p_sel_rb)
        else $error("channel select readback wrong");
    property p_start_rb;
        PORT_RD_IN && off inside {16'h2, 16'h4, 16'h6, 16'h8}
            |=> PORT_RDATA_OUT == $past(exp);
    endproperty
    a_start_rb: assert property (p_start_rb)
        else $error("start value readback wrong");
    property p_hole;
        PORT_RD_IN && hole |=> PORT_RDATA_OUT == 16'h0000;
    endproperty
    a_hole: assert property (p_hole)
        else $error("unmapped read not zero");
    property p_oe;
        RUN_LINE_OE_OUT == !(ctl_reg[1] && ctl_reg[0]
            && !(ctl_reg[3] && TERMINAL_FLAG_OUT));
    endproperty
    a_oe: assert property (p_oe)
        else $error("run line drive wrong");
    property p_term_clr;
        PORT_WR_IN && off == 16'h0000 && PORT_WDATA_IN[12]
            && PORT_WDATA_IN[11:10] == 2'b00 && ctl_reg[11:10] == 2'b00
            |=> !TERMINAL_FLAG_OUT;
    endproperty
    a_term_clr: assert property (p_term_clr)
        else $error("terminal flag not cleared");
    property p_term_src;
        $rose(TERMINAL_FLAG_OUT) |-> $past(ctl_reg[11:10]) != 2'b00;
    endproperty
    a_term_src: assert property (p_term_src)
        else $error("terminal flag without terminal mode");
endmodule // scrd_chk
bind scrd_top scrd_chk #(.BASE_ADDR(BASE_ADDR)) u_chk (.CLK_SYS_IN, .ARST_N_IN,
    .PORT_ADDR_IN, .PORT_RD_IN, .PORT_WR_IN, .PORT_WDATA_IN, .PORT_RDATA_OUT,
    .RUN_LINE_OE_OUT, .TERMINAL_FLAG_OUT);
`default_nettype wire

//--- tb/scrd_host.sv
// host model: port reads and writes at the card's base address
`timescale 1ns/1ps
`default_nettype none
module scrd_host
    import scrd_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic [15:0] rdata_in,
    output var  scrd_bus_s   bus_out
);
    initial bus_out = '0;
    // one strobe cycle per access; released data is inverted, not held
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge clk_in);
        bus_out = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge clk_in);
        bus_out.wr = 1'b0;
        bus_out.wdata = ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(negedge clk_in);
        bus_out = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(negedge clk_in);
        d = rdata_in;
        bus_out.rd = 1'b0;
    endtask
endmodule // scrd_host
`default_nettype wire

//--- tb/scaler_card_host_registers_tb.sv
// testbench: register access, status, terminal count, snapshot, timer
`timescale 1ns/1ps
`default_nettype none
module scaler_card_host_registers_tb;
    import scrd_pkg::*;
    logic           clk = 1'b0;
    logic           arst_n = 1'b0;
    logic [NCH-1:0] cnt = '0;
    logic           win = 1'b0;
    logic           ld = 1'b0;
    logic [15:0]    rdata, rv;
    logic           oe, term, carry;
    scrd_bus_s      bus;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    always #50 clk = ~clk;
    scrd_host u_host (.clk_in(clk), .rdata_in(rdata), .bus_out(bus));
    scrd_top u_dut (.CLK_SYS_IN(clk), .ARST_N_IN(arst_n),
        .PORT_ADDR_IN(BASE_DEFAULT + {12'h000, bus.addr}),
        .PORT_RD_IN(bus.rd), .PORT_WR_IN(bus.wr), .PORT_WDATA_IN(bus.wdata),
        .PORT_RDATA_OUT(rdata), .COUNT_IN(cnt), .WINDOW_IN(win), .LOAD_IN(ld),
        .RUN_LINE_IN(!oe), .RUN_LINE_OUT(), .RUN_LINE_OE_OUT(oe),
        .CARRY_PULSE_OUTPUT_OUT(carry), .TERMINAL_FLAG_OUT(term));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
        u_host.rd(a, rv);
        chk(rv, exp);
    endtask
    task automatic t_regs;
        rchk(OFF_CONTROL, CONTROL_RESET);
        u_host.wr(OFF_CONTROL, 16'h6cf0);
        u_host.wr(OFF_STATUS, 16'h00ff);
        rchk(OFF_CONTROL, 16'h6cf0);
        u_host.wr(OFF_CHSEL, 16'h00a5);
        rchk(OFF_CHSEL, 16'h00a5);
        for (int i = 1; i <= 4; i++) begin
            u_host.wr(4'(2 * i), 16'(16'h1111 * i));
        end
        u_host.wr(4'h5, 16'hffff);
        for (int i = 1; i <= 4; i++) begin
            rchk(4'(2 * i), 16'(16'h1111 * i));
        end
        rchk(4'h5, 16'h0000);
    endtask
    task automatic t_status;
        u_host.wr(OFF_CONTROL, 16'h0043);
        for (int i = 0; i < 2; i++) begin
            win = i[0];
            ld = i[0];
            repeat (5) @(negedge clk);
            rchk(OFF_STATUS, {11'h000, 1'b0, i[0], i[0], 1'b1, 1'b0});
        end
        chk({15'h0000, oe}, 16'h0000);
    endtask
    task automatic t_preset;
        u_host.wr(OFF_START_LO0, 16'hfff0);
        u_host.wr(OFF_START_HI0, 16'h0fff);
        u_host.wr(OFF_CONTROL, 16'h054b);
        repeat (20) begin
            @(negedge clk);
            cnt = 12'h005;
            @(negedge clk);
            cnt = '0;
        end
        repeat (5) @(negedge clk);
        chk({14'h0000, oe, term}, 16'h0003);
        u_host.wr(OFF_CONTROL, 16'h064b);
        u_host.wr(OFF_CHSEL, 16'h0000);
        rchk(OFF_SNAP_LO, 16'hffff);
        rchk(OFF_SNAP_HI, 16'h0fff);
        u_host.wr(OFF_CHSEL, 16'h0002);
        rchk(OFF_SNAP_LO, 16'h0014);
        u_host.wr(OFF_CONTROL, 16'h004b);
        u_host.wr(OFF_CONTROL, 16'h104b);
        chk({14'h0000, oe, term}, 16'h0000);
    endtask
    task automatic t_timer;
        u_host.wr(OFF_START_LO0, 16'h0000);
        u_host.wr(OFF_CHSEL, 16'h0000);
        u_host.wr(OFF_CONTROL, 16'h2141);
        repeat (10) @(negedge clk);
        u_host.wr(OFF_CONTROL, 16'h2241);
        u_host.rd(OFF_SNAP_LO, rv);
        chk(16'(rv % 16'd10 == 16'd0 && rv > 16'd50), 16'h0001);
    endtask
    // pulses on channel 2, then time for the two-flop sync and edge stage
    task automatic pulse2(input int n);
        repeat (n) begin
            @(negedge clk);
            cnt = 12'h004;
            @(negedge clk);
            cnt = '0;
        end
        repeat (5) @(negedge clk);
    endtask
    task automatic t_gate;
        u_host.wr(OFF_CHSEL, 16'h0002);
        u_host.wr(OFF_CONTROL, 16'h0161);
        pulse2(4);
        u_host.wr(OFF_CONTROL, 16'h0261);
        rchk(OFF_SNAP_LO, 16'h0000);
        win = 1'b0;
        repeat (4) @(negedge clk);
        pulse2(3);
        u_host.wr(OFF_CONTROL, 16'h0261);
        rchk(OFF_SNAP_LO, 16'h0003);
    endtask
    task automatic t_run_carry;
        u_host.wr(OFF_CONTROL, 16'h0145);
        repeat (4) @(negedge clk);
        pulse2(3);
        u_host.wr(OFF_CONTROL, 16'h0245);
        rchk(OFF_SNAP_LO, 16'h0000);
        u_host.wr(OFF_CONTROL, 16'h0147);
        repeat (4) @(negedge clk);
        pulse2(2);
        u_host.wr(OFF_CONTROL, 16'h0247);
        rchk(OFF_SNAP_LO, 16'h0002);
        u_host.wr(OFF_CHSEL, 16'h0042);
        @(negedge clk);
        chk({15'h0000, carry}, 16'h0000);
        u_host.wr(OFF_CHSEL, 16'h0012);
        @(negedge clk);
        chk({15'h0000, carry}, 16'h0001);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ceiling well above the few hundred cycles the scenarios need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        t_regs();
        t_status();
        t_preset();
        t_timer();
        t_gate();
        t_run_carry();
        tally_and_finish();
    end
endmodule // scaler_card_host_registers_tb
`default_nettype wire
